// [common/pssc_pkg.sv]
// Shared constants for the pipelined synchronous burst memory device.
package pssc_pkg;

	// Data lane layout: each byte lane carries eight data bits and one parity bit.
	localparam int unsigned BYTE_W    = 8;
	localparam int unsigned LANE_W    = 9;
	localparam int unsigned PAR_POS   = 8;

	// Burst counter covers the two lowest address bits.
	localparam int unsigned LOW_W     = 2;

	// Burst order strap encodings (strap low selects linear order).
	localparam logic ORDER_LINEAR      = 1'b0;
	localparam logic ORDER_INTERLEAVED = 1'b1;

	// Values after reset.
	localparam logic [1:0] RST_STEP    = 2'h0;
	localparam logic [1:0] RST_BASE    = 2'h0;
	localparam logic       RST_ACTIVE  = 1'b0;
	localparam logic       RST_OE_N    = 1'b1;
	localparam logic       RST_SLEEP   = 1'b0;
	localparam logic [8:0] RST_LANE    = 9'h000;

	// Cycles from a selected read access to the data being driven.
	localparam int unsigned READ_LATENCY = 1;

endpackage

// [rtl/pssc_sram_dev.sv]
// Pipelined synchronous burst memory device: strobes, selects, burst counter, byte writes, data pins.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////////////////////////
module pssc_sram_dev #(
	parameter int unsigned ADDR_W    = 10,
	parameter int unsigned NUM_BYTES = 4
) (
	// Clock and reset.
	input  wire logic                             REF_CLK_IN,
	input  wire logic                             RESETN_IN,
	// Address and access control, synchronous to the clock.
	input  wire logic [ADDR_W-1:0]                ADDR_IN,
	input  wire logic                             CHIP_SEL_PRIMARY_N_IN,
	input  wire logic                             CHIP_SEL_DEPTH_HI_IN,
	input  wire logic                             CHIP_SEL_DEPTH_LO_N_IN,
	input  wire logic                             PROC_ADDR_STROBE_N_IN,
	input  wire logic                             CTRL_ADDR_STROBE_N_IN,
	input  wire logic                             BURST_ADVANCE_N_IN,
	input  wire logic                             ALL_BYTE_WRITE_N_IN,
	input  wire logic                             BYTE_WRITE_EN_N_IN,
	input  wire logic [NUM_BYTES-1:0]             BYTE_SEL_N_IN,
	// Asynchronous controls and strap.
	input  wire logic                             OUT_EN_N_IN,
	input  wire logic                             SLEEP_REQ_IN,
	input  wire logic                             BURST_ORDER_IN,
	// Data and parity pins, split into input, output and enable.
	input  wire logic [NUM_BYTES*8-1:0]           DATA_IN,
	output logic      [NUM_BYTES*8-1:0]           DATA_OUT,
	output logic                                  DATA_OE_OUT,
	input  wire logic [NUM_BYTES-1:0]             PARITY_LINES_IN,
	output logic      [NUM_BYTES-1:0]             PARITY_LINES_OUT,
	output logic                                  PARITY_LINES_OE_OUT,
	// Status.
	output logic                                  ASLEEP_OUT
);

	localparam int unsigned DEPTH = 1 << ADDR_W;

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Synchronisers for the asynchronous pins.

	logic                    oe_n_s1_ff;
	logic                    oe_n_s2_ff;
	logic                    sleep_s1_ff;
	logic                    sleep_s2_ff;
	logic                    order_s1_ff;
	logic                    order_s2_ff;

	// Output enable, sleep and strap are asynchronous; the strap is static so two flops suffice.
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			oe_n_s1_ff  <= pssc_pkg::RST_OE_N;
			oe_n_s2_ff  <= pssc_pkg::RST_OE_N;
			sleep_s1_ff <= pssc_pkg::RST_SLEEP;
			sleep_s2_ff <= pssc_pkg::RST_SLEEP;
			order_s1_ff <= pssc_pkg::ORDER_INTERLEAVED;
			order_s2_ff <= pssc_pkg::ORDER_INTERLEAVED;
		end
		else
		begin
			oe_n_s1_ff  <= OUT_EN_N_IN;
			oe_n_s2_ff  <= oe_n_s1_ff;
			sleep_s1_ff <= SLEEP_REQ_IN;
			sleep_s2_ff <= sleep_s1_ff;
			order_s1_ff <= BURST_ORDER_IN;
			order_s2_ff <= order_s1_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Access decode.

	logic                    active_ff;
	logic [ADDR_W-3:0]       addr_hi_ff;
	logic [1:0]              base_ff;
	logic [1:0]              step_ff;
	logic                    asleep;
	logic                    ld_proc;
	logic                    ld_ctrl;
	logic                    ld_any;
	logic                    sel;
	logic                    ld_sel;
	logic                    cont;
	logic                    advance;
	logic                    emerge;
	logic [1:0]              nxt_step;
	logic [1:0]              nxt_base;
	logic [1:0]              low_addr_bits;
	logic [ADDR_W-1:0]       acc_addr;
	logic [NUM_BYTES-1:0]    wr_mask;
	logic                    wr_now;
	logic                    rd_now;

	// Sleep blocks every new access; stored contents stay untouched.
	assign asleep   = sleep_s2_ff;
	// The processor strobe counts only with the primary select low.
	assign ld_proc  = !PROC_ADDR_STROBE_N_IN && !CHIP_SEL_PRIMARY_N_IN && !asleep;
	// The controller strobe is dropped when the processor strobe is taken.
	assign ld_ctrl  = !CTRL_ADDR_STROBE_N_IN && !ld_proc && !asleep;
	assign ld_any   = ld_proc || ld_ctrl;
	// Select decode, looked at only in load cycles.
	assign sel      = !CHIP_SEL_PRIMARY_N_IN && CHIP_SEL_DEPTH_HI_IN && !CHIP_SEL_DEPTH_LO_N_IN;
	assign ld_sel   = ld_any && sel;
	assign cont     = active_ff && !ld_any && !asleep;
	// Advance has effect only inside an active burst.
	assign advance  = cont && !BURST_ADVANCE_N_IN;
	assign emerge   = ld_sel && !active_ff;
	assign nxt_step = ld_sel ? pssc_pkg::RST_STEP : (advance ? 2'(step_ff + 2'h1) : step_ff);
	assign nxt_base = ld_sel ? ADDR_IN[1:0] : base_ff;
	// Two-bit wrap in linear or interleaved order.
	assign low_addr_bits = (order_s2_ff == pssc_pkg::ORDER_LINEAR) ? 2'(nxt_base + nxt_step)
	                                                              : (nxt_base ^ nxt_step);
	assign acc_addr = ld_sel ? ADDR_IN : {addr_hi_ff, low_addr_bits};

	// Global write overrides the byte lanes.
	assign wr_mask  = !ALL_BYTE_WRITE_N_IN ? {NUM_BYTES{1'b1}}
	                : (!BYTE_WRITE_EN_N_IN ? ~BYTE_SEL_N_IN : {NUM_BYTES{1'b0}});
	// Write controls are ignored in the processor-strobe load cycle.
	assign wr_now   = (ld_sel || cont) && !ld_proc && (|wr_mask);
	assign rd_now   = (ld_sel || cont) && !wr_now;

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Address register and burst counter.

	// Address and counter step on the clock edge only.
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			addr_hi_ff <= '0;
			base_ff    <= pssc_pkg::RST_BASE;
			step_ff    <= pssc_pkg::RST_STEP;
		end
		else
		begin
			if (ld_sel)
				addr_hi_ff <= ADDR_IN[ADDR_W-1:2];
			base_ff <= nxt_base;
			step_ff <= nxt_step;
		end
	end

	// Selection state; a deselecting load ends the burst, sleep ends it too.
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
			active_ff <= pssc_pkg::RST_ACTIVE;
		else if (ld_any)
			active_ff <= sel;
		else if (asleep)
			active_ff <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Write pipeline: data is registered at the edge, committed to the array one cycle later.

	logic [NUM_BYTES*8-1:0]  din_ff;
	logic [NUM_BYTES-1:0]    din_par_ff;
	logic                    wr_pend_ff;
	logic [NUM_BYTES-1:0]    wr_mask_ff;
	logic [ADDR_W-1:0]       wr_addr_ff;
	logic                    drive_ff;

	// Data and parity pins are latched every edge.
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			din_ff     <= '0;
			din_par_ff <= '0;
			wr_pend_ff <= 1'b0;
			wr_mask_ff <= '0;
			wr_addr_ff <= '0;
		end
		else
		begin
			din_ff     <= DATA_IN;
			din_par_ff <= PARITY_LINES_IN;
			wr_pend_ff <= wr_now;
			wr_mask_ff <= wr_now ? wr_mask : {NUM_BYTES{1'b0}};
			wr_addr_ff <= acc_addr;
		end
	end

	// Drive only after a read, with enable low, never on the first cycle out of deselect.
	// The enable passes a synchroniser, so it acts two cycles late; that trades speed for safety.
	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
			drive_ff <= 1'b0;
		else
			drive_ff <= rd_now && !oe_n_s2_ff && !emerge;
	end

	assign DATA_OE_OUT         = drive_ff; // Data and parity pins share one registered enable.
	assign PARITY_LINES_OE_OUT = drive_ff;
	assign ASLEEP_OUT          = sleep_s2_ff;

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Byte lanes: storage, bypass of a pending write, registered read data.

	generate
		for (genvar i = 0; i < NUM_BYTES; i++)
		begin : g_lane
			logic [pssc_pkg::LANE_W-1:0] lane_mem [0:DEPTH-1];
			logic [pssc_pkg::LANE_W-1:0] wr_word;
			logic [pssc_pkg::LANE_W-1:0] q_ff;
			logic                        hit;

			assign wr_word = {din_par_ff[i], din_ff[i*pssc_pkg::BYTE_W +: pssc_pkg::BYTE_W]};
			assign hit     = wr_mask_ff[i] && (wr_addr_ff == acc_addr);

			// Lanes outside the mask keep their contents.
			always_ff @(posedge REF_CLK_IN)
			begin
				if (wr_mask_ff[i])
					lane_mem[wr_addr_ff] <= wr_word;
			end

			// Read result lands one edge after the address; a just-written word is forwarded.
			always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
			begin
				if (!RESETN_IN)
					q_ff <= pssc_pkg::RST_LANE;
				else if (rd_now)
					q_ff <= hit ? wr_word : lane_mem[acc_addr];
			end

			assign DATA_OUT[i*pssc_pkg::BYTE_W +: pssc_pkg::BYTE_W] = q_ff[pssc_pkg::BYTE_W-1:0];
			assign PARITY_LINES_OUT[i] = q_ff[pssc_pkg::PAR_POS];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!RESETN_IN);

	chk_drive_needs_oe: assert property (DATA_OE_OUT |-> $past(!oe_n_s2_ff) && $past(rd_now))
		else $error("data driven without enable and read");
	chk_emerge_masked: assert property (emerge |=> !DATA_OE_OUT)
		else $error("outputs driven on first cycle out of deselect");
	chk_addr_capture: assert property (ld_sel |=> addr_hi_ff == $past(ADDR_IN[ADDR_W-1:2])
		&& base_ff == $past(ADDR_IN[1:0]) && step_ff == 2'h0)
		else $error("address or counter not loaded on strobe");
	chk_ctrl_load: assert property (!CTRL_ADDR_STROBE_N_IN && PROC_ADDR_STROBE_N_IN && sel && !asleep
		|=> active_ff && base_ff == $past(ADDR_IN[1:0]))
		else $error("controller strobe did not load");
	chk_proc_wins: assert property (!PROC_ADDR_STROBE_N_IN && !CTRL_ADDR_STROBE_N_IN
		&& !CHIP_SEL_PRIMARY_N_IN && !asleep |=> !wr_pend_ff)
		else $error("controller strobe acted alongside processor strobe");
	chk_proc_ignored: assert property (!PROC_ADDR_STROBE_N_IN && CHIP_SEL_PRIMARY_N_IN
		&& CTRL_ADDR_STROBE_N_IN |=> $stable(addr_hi_ff) && $stable(base_ff))
		else $error("processor strobe taken with primary select high");
	chk_advance_step: assert property (advance |=> step_ff == $past(step_ff) + 2'h1)
		else $error("burst counter did not advance");
	chk_idle_advance: assert property (!active_ff && !ld_any |=> $stable(step_ff))
		else $error("advance changed address outside a burst");
	chk_deselect_ends: assert property (ld_any && !sel |=> !active_ff ##1 !DATA_OE_OUT)
		else $error("device stayed selected after deselecting load");
	chk_cont_sel: assert property (cont |=> active_ff)
		else $error("select pins acted during burst continuation");
	chk_all_lanes: assert property (wr_now && !ALL_BYTE_WRITE_N_IN |=> wr_mask_ff == {NUM_BYTES{1'b1}})
		else $error("global write missed a lane");
	chk_sleep_quiet: assert property (asleep |=> !wr_pend_ff ##1 !DATA_OE_OUT)
		else $error("activity while asleep");

	cov_burst_four: cover property (ld_sel ##1 advance ##1 advance ##1 advance);
	cov_write_ctrl: cover property (ld_ctrl && sel && wr_now);
	cov_read_drive: cover property (rd_now && !emerge ##1 DATA_OE_OUT);
	cov_sleep: cover property (active_ff ##1 asleep);

endmodule

// [verif/pssc_master_model.sv]
// Bus master model that drives the memory pins and resolves the shared data wire.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module pssc_master_model (
	// Clock.
	input  wire logic        clk_in,
	// Device side of the data and parity pins.
	input  wire logic [35:0] dev_data_in,
	input  wire logic        dev_oe_in,
	// Pins driven by the master.
	output logic      [9:0]  addr_out,
	output logic      [7:0]  ctl_out,
	output logic      [3:0]  bsel_out,
	output logic      [35:0] wire_out
);
	logic        drive;
	logic [35:0] wdata;
	logic [35:0] last_ff;

	// The wire has no pull, so a cycle nobody drives shows the inverse of the last level.
	assign wire_out = dev_oe_in ? dev_data_in : (drive ? wdata : ~last_ff);

	// Remember the wire level at each edge.
	always @(posedge clk_in)
		last_ff <= wire_out;

	// Idle with the device selected and both strobes high.
	initial
	begin
		addr_out = 10'h000;
		ctl_out  = 8'hEB;
		bsel_out = 4'hF;
		drive    = 1'b0;
		wdata    = 36'h0;
		last_ff  = 36'h0;
	end

	// One bus cycle: pins change just after an edge and hold until the next one.
	task automatic cyc(input logic [9:0] a, input logic [7:0] c, input logic [3:0] bs, input logic dr,
		input logic [35:0] wd);
		addr_out = a;
		ctl_out  = c;
		bsel_out = bs;
		drive    = dr;
		wdata    = wd;
		@(posedge clk_in);
		#1;
	endtask
endmodule

// [verif/pssc_sram_dev_test.sv]
// Self-checking bench for the pipelined burst memory device.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module pssc_sram_dev_test;
	// Codes {proc strobe, ctrl strobe, advance, sel primary, sel hi, sel lo, global write, byte write}.
	localparam logic [7:0] C_IDLE = 8'hEB;
	localparam logic [7:0] C_PRD  = 8'h6B;
	localparam logic [7:0] C_GWR  = 8'hA9;
	localparam logic [7:0] C_BWR  = 8'hAA;
	localparam logic [7:0] C_STEP = 8'hCB;
	localparam logic [7:0] C_DSEL = 8'hA3;
	localparam logic [7:0] C_PIGN = 8'h7B;
	localparam logic [7:0] C_BOTH = 8'h29;
	localparam logic [7:0] C_ADVX = 8'hD3;
	localparam logic [7:0] C_CWR  = 8'hE9;
	logic        clk;
	logic        rst_n;
	logic        oe_n;
	logic        sleep;
	logic        order;
	logic [9:0]  addr;
	logic [7:0]  ctl;
	logic [3:0]  bsel;
	logic [35:0] bus;
	logic [31:0] d_out;
	logic [3:0]  p_out;
	logic        d_oe;
	logic        p_oe;
	logic        asleep;
	logic [35:0] mem [16];
	int          failures;
	int          checks_done;

	// Design and its bus master.
	pssc_sram_dev pssc_sram_dev_inst (.REF_CLK_IN(clk), .RESETN_IN(rst_n), .ADDR_IN(addr),
		.CHIP_SEL_PRIMARY_N_IN(ctl[4]), .CHIP_SEL_DEPTH_HI_IN(ctl[3]), .CHIP_SEL_DEPTH_LO_N_IN(ctl[2]),
		.PROC_ADDR_STROBE_N_IN(ctl[7]), .CTRL_ADDR_STROBE_N_IN(ctl[6]), .BURST_ADVANCE_N_IN(ctl[5]),
		.ALL_BYTE_WRITE_N_IN(ctl[1]), .BYTE_WRITE_EN_N_IN(ctl[0]), .BYTE_SEL_N_IN(bsel),
		.OUT_EN_N_IN(oe_n), .SLEEP_REQ_IN(sleep), .BURST_ORDER_IN(order), .DATA_IN(bus[31:0]),
		.DATA_OUT(d_out), .DATA_OE_OUT(d_oe), .PARITY_LINES_IN(bus[35:32]), .PARITY_LINES_OUT(p_out),
		.PARITY_LINES_OE_OUT(p_oe), .ASLEEP_OUT(asleep));
	pssc_master_model pssc_master_model_inst (.clk_in(clk), .dev_data_in({p_out, d_out}), .dev_oe_in(d_oe),
		.addr_out(addr), .ctl_out(ctl), .bsel_out(bsel), .wire_out(bus));

	// Clock at 200 MHz.
	always #2.5 clk = ~clk;

	// Pattern stored at each address; parity bits included.
	function automatic logic [35:0] pat(input logic [9:0] a);
		return {a[3:0], 2'h1, a, ~a, a};
	endfunction

	// Compare and count.
	task automatic cmp(input logic [35:0] exp, input logic [35:0] got);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: expected %h got %h", $time, exp, got);
		end
	endtask

	// Check the drive enables and, when driving, the read data of the current output cycle.
	task automatic rd(input logic oe, input logic [35:0] exp);
		cmp({34'h0, oe, oe}, {34'h0, d_oe, p_oe});
		if (oe)
			cmp(exp, {p_out, d_out});
	endtask

	// One bus cycle with the master's data drivers off.
	task automatic go(input logic [9:0] a, input logic [7:0] c);
		pssc_master_model_inst.cyc(a, c, 4'hF, 1'b0, 36'h0);
	endtask

	// Back-to-back controller-strobe writes; outputs are turned off first to avoid contention.
	task automatic wr(input logic [9:0] b, input logic [7:0] c, input logic [3:0] bs, input int n,
		input logic [35:0] x);
		oe_n = 1'b1;
		repeat (3) go(b, C_IDLE);
		rd(1'b0, 36'h0);
		for (int i = 0; i < n; i++)
			pssc_master_model_inst.cyc(10'(b + i), c, bs, 1'b1, pat(10'(b + i)) ^ x);
		go(b, C_IDLE);
		oe_n = 1'b0;
		repeat (2) go(b, C_IDLE);
	endtask

	task automatic s_linear;
		order = 1'b0;
		wr(10'h004, C_GWR, 4'hF, 4, 36'h0);
		for (int i = 4; i < 8; i++)
			mem[i] = pat(10'(i));
		go(10'h000, C_DSEL);
		go(10'h000, C_STEP);
		rd(1'b0, 36'h0);
		go(10'h006, C_PRD);
		rd(1'b0, 36'h0);
		go(10'h3FF, C_IDLE);
		rd(1'b1, mem[6]);
		go(10'h3FF, C_STEP);
		rd(1'b1, mem[7]);
		go(10'h3FF, C_STEP);
		rd(1'b1, mem[4]);
		go(10'h3FF, C_STEP);
		rd(1'b1, mem[5]);
		go(10'h000, C_ADVX);
		rd(1'b1, mem[6]);
		go(10'h001, C_PIGN);
		rd(1'b1, mem[6]);
		pssc_master_model_inst.cyc(10'h005, C_BOTH, 4'hF, 1'b1, 36'h0);
		rd(1'b1, mem[5]);
		go(10'h005, C_IDLE);
		rd(1'b1, mem[5]);
	endtask

	task automatic s_bytes;
		wr(10'h005, C_BWR, 4'hA, 1, 36'hF_FFFF_FFFF);
		mem[5] = mem[5] ^ 36'h5_00FF_00FF;
		go(10'h005, C_PRD);
		rd(1'b1, mem[5]);
	endtask

	task automatic s_interleave;
		wr(10'h008, C_GWR, 4'hF, 4, 36'h0);
		for (int i = 8; i < 12; i++)
			mem[i] = pat(10'(i));
		order = 1'b1;
		repeat (3) go(10'h000, C_IDLE);
		go(10'h009, C_PRD);
		rd(1'b1, mem[9]);
		go(10'h000, C_STEP);
		rd(1'b1, mem[8]);
		go(10'h000, C_STEP);
		rd(1'b1, mem[11]);
		go(10'h000, C_STEP);
		rd(1'b1, mem[10]);
	endtask

	// Processor-started write: the load cycle reads, the next cycle carries the write controls.
	task automatic s_proc_write;
		oe_n = 1'b1;
		repeat (3) go(10'h00C, C_IDLE);
		go(10'h00C, C_PRD);
		pssc_master_model_inst.cyc(10'h000, C_CWR, 4'hF, 1'b1, pat(10'h00C));
		mem[12] = pat(10'h00C);
		oe_n = 1'b0;
		repeat (2) go(10'h000, C_IDLE);
		go(10'h00C, C_PRD);
		rd(1'b1, mem[12]);
	endtask

	task automatic s_sleep;
		sleep = 1'b1;
		repeat (3) go(10'h000, C_IDLE);
		cmp(36'h1, {35'h0, asleep});
		wr(10'h008, C_GWR, 4'hF, 1, 36'hF_FFFF_FFFF);
		sleep = 1'b0;
		repeat (3) go(10'h000, C_IDLE);
		cmp(36'h0, {35'h0, asleep});
		go(10'h008, C_PRD);
		rd(1'b0, 36'h0);
		go(10'h008, C_IDLE);
		rd(1'b1, mem[8]);
	endtask

	task automatic print_verdict;
		if (failures == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Main sequence: reset for four cycles, then the scenarios.
	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		oe_n = 1'b0;
		sleep = 1'b0;
		order = 1'b0;
		failures = 0;
		checks_done = 0;
		repeat (4) @(posedge clk);
		#1;
		rst_n = 1'b1;
		rd(1'b0, 36'h0);
		cmp(36'h0, {35'h0, asleep});
		s_linear();
		s_bytes();
		s_interleave();
		s_proc_write();
		s_sleep();
		print_verdict();
	end

	// Watchdog: the scenarios take well under a hundred cycles.
	initial
	begin
		#3000;
		failures++;
		print_verdict();
	end
endmodule
